// ---- rtl/spi_eeprom_status_protect.sv ----
// write latch, status register and write protection of a serial eeprom
// assumes serial_clock idles when select_n is high for this device only
// as far as this block cares; array path asks leave via array_wr_req
//
// Contract
// RULE1: latch set only by set-latch command
// RULE2: after set-latch, ignore bus until deselect
// RULE3: clear-latch resets latch, then wait
// RULE4: latch clears on reset, clear, write ends
// RULE5: status read accepted at any time
// RULE6: status byte repeats while still selected
// RULE7: host polls busy before new commands
// RULE8: busy reads 1 during write cycles
// RULE9: latch clear rejects all write commands
// RULE10: status byte bit layout fixed
// RULE11: protect selects nonvolatile, block array writes
// RULE12: lock plus pin low refuses status write
// RULE13: status write needs latch set first
// RULE14: status write exactly opcode plus one byte
// RULE15: deselect at boundary starts timed cycle
// RULE16: busy falls and latch clears at end
// RULE17: new protection bits apply after cycle
// RULE18: status write spares b6-b4,b1,b0
// RULE19: lock zero allows write, either pin
// RULE20: lock one, pin high allows write
// RULE21: lock mode entered in either order
// RULE22: only pin high leaves lock mode; here also rst, or a b7-clear status write begun before the pin fell
// RULE23: msb first, opcodes 06 04 05 01
// RULE24: unknown opcode waits for deselect
// RULE25: execute only if deselected after last bit
// RULE26: protect codes map to address regions
// RULE27: sample rising, drive falling, drive only reading
`timescale 1ns/100ps

module spi_eeprom_status_protect
	import eeprom_status_pkg::*;
#(
	parameter int unsigned TW_CYCLES = TW_CYCLES_DEF
)
(
	// system
	input wire logic clk,
	input wire logic rst,
	// serial link
	input wire logic serial_clock,
	input wire logic select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe_n,
	input wire logic protect_pin_n,
	// array write path
	input wire logic array_wr_req,
	input wire logic [10:0] array_wr_addr,
	output logic array_wr_ok,
	output logic array_wr_reject,
	// status view
	output logic [7:0] status_byte,
	output logic hardware_lock_mode,
	output logic software_lock_mode
);

	// ==========================================================
	// region check for array writes
	function automatic logic region_protected(input logic [1:0] sel, input logic [10:0] addr);
		logic hit;
		hit = 1'b0;
		unique case (sel)
			2'b00: hit = 1'b0;
			2'b01: hit = (addr >= QUARTER_BASE); // RULE26
			2'b10: hit = (addr >= HALF_BASE); // RULE26
			2'b11: hit = 1'b1; // RULE26
		endcase
		return hit;
	endfunction

	// ==========================================================
	// link side: shifter on serial_clock
	logic link_rst;
	logic [4:0] cnt_q;
	logic over_q;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] op_q;
	logic reading_q;
	link_req_s pend_q;
	link_req_s pend_d;
	logic [7:0] stat_meta_q;
	logic [7:0] stat_sync_q;
	logic [7:0] stat_hold_q;
	logic [7:0] tx_q;
	logic sout_q;
	logic oe_n_q;

	// deselect ends the frame and holds the shifter cleared
	assign link_rst = rst | select_n;
	assign shift_d = {shift_q[6:0], serial_in}; // RULE23

	// bit counter, wraps over the data byte to allow repeated status bytes
	always_ff @(posedge serial_clock or posedge link_rst)
	begin
		if (link_rst)
		begin
			cnt_q <= 5'd0;
			over_q <= 1'b0;
			shift_q <= 8'h00;
		end
		else
		begin
			shift_q <= shift_d; // RULE27
			if (cnt_q == FRAME_WRAP_CNT)
			begin
				cnt_q <= FRAME_RESTART_CNT;
				over_q <= 1'b1;
			end
			else
				cnt_q <= cnt_q + 5'd1;
		end
	end

	// opcode capture and read mode
	always_ff @(posedge serial_clock or posedge link_rst)
	begin
		if (link_rst)
		begin
			op_q <= 8'h00;
			reading_q <= 1'b0;
		end
		else if (cnt_q == OPCODE_LAST_CNT)
		begin
			op_q <= shift_d;
			reading_q <= (shift_d == STATUS_READ_CMD); // RULE5
		end
	end

	// request seen at the current edge; any later edge cancels it
	always_comb
	begin
		pend_d.kind = cmd_none;
		pend_d.data = 8'h00;
		if (cnt_q == OPCODE_LAST_CNT)
		begin
			if (shift_d == SET_WRITE_LATCH_CMD)
				pend_d.kind = cmd_set_latch; // RULE1
			else if (shift_d == CLEAR_WRITE_LATCH_CMD)
				pend_d.kind = cmd_clear_latch;
		end
		else if (cnt_q == DATA_LAST_CNT && !over_q && op_q == STATUS_WRITE_CMD)
		begin
			pend_d.kind = cmd_status_write; // RULE14
			pend_d.data = shift_d;
		end
	end

	// request held across deselect; only edges while selected touch it
	always_ff @(posedge serial_clock or posedge rst)
	begin
		if (rst)
			pend_q <= '{kind: cmd_none, data: 8'h00};
		else if (!select_n)
			pend_q <= pend_d; // RULE2 RULE24 RULE25
	end

	// status byte carried into the link domain; only a value seen on two edges in a row
	// is kept, so a byte caught while several bits change is never shifted out
	always_ff @(posedge serial_clock or posedge rst)
	begin
		if (rst)
		begin
			stat_meta_q <= 8'h00;
			stat_sync_q <= 8'h00;
			stat_hold_q <= 8'h00;
		end
		else
		begin
			stat_meta_q <= status_byte;
			stat_sync_q <= stat_meta_q;
			if (stat_meta_q == stat_sync_q)
				stat_hold_q <= stat_sync_q;
		end
	end

	// read data leaves on falling edges, reloaded at every byte boundary
	always_ff @(negedge serial_clock or posedge link_rst)
	begin
		if (link_rst)
		begin
			tx_q <= 8'h00;
			sout_q <= 1'b0;
			oe_n_q <= 1'b1;
		end
		else
		begin
			oe_n_q <= ~reading_q; // RULE27
			if (reading_q && cnt_q[2:0] == BYTE_EDGE_BITS)
			begin
				tx_q <= {stat_hold_q[6:0], 1'b0}; // RULE6
				sout_q <= stat_hold_q[7];
			end
			else
			begin
				tx_q <= {tx_q[6:0], 1'b0};
				sout_q <= tx_q[7];
			end
		end
	end

	assign serial_out = sout_q;
	assign serial_out_oe_n = oe_n_q;

	// ==========================================================
	// system side: pin synchronisers
	logic sel_meta_q;
	logic sel_sync_q;
	logic sel_prev_q;
	logic prot_meta_q;
	logic prot_sync_q;
	logic sel_rise;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sel_meta_q <= 1'b1;
			sel_sync_q <= 1'b1;
			sel_prev_q <= 1'b1;
			prot_meta_q <= 1'b1;
			prot_sync_q <= 1'b1;
		end
		else
		begin
			sel_meta_q <= select_n;
			sel_sync_q <= sel_meta_q;
			sel_prev_q <= sel_sync_q;
			prot_meta_q <= protect_pin_n;
			prot_sync_q <= prot_meta_q;
		end
	end

	assign sel_rise = sel_sync_q & ~sel_prev_q;

	// ==========================================================
	// decisions
	logic latch_q;
	logic busy_q;
	logic lock_q;
	logic [1:0] psel_q;
	logic [TIMER_W-1:0] timer_q;
	logic cyc_status_q;
	logic [7:0] staged_q;
	logic hw_lock_now;
	logic status_write_cmd_go;
	logic arr_go;
	logic cycle_end;

	assign hw_lock_now = lock_q & ~prot_sync_q; // RULE21 RULE22
	// refused without latch, during a cycle, or in lock mode
	assign status_write_cmd_go = sel_rise && pend_q.kind == cmd_status_write && latch_q
		&& !busy_q && !hw_lock_now; // RULE9 RULE12 RULE13 RULE19 RULE20
	assign arr_go = array_wr_req && latch_q && !busy_q && !status_write_cmd_go
		&& !region_protected(psel_q, array_wr_addr); // RULE9 RULE11
	assign cycle_end = busy_q && (timer_q == TIMER_W'(TW_CYCLES - 1));

	// write latch: a set arriving with a clear wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			latch_q <= WRITE_LATCH_RST; // RULE4
		else if (sel_rise && pend_q.kind == cmd_set_latch)
			latch_q <= 1'b1; // RULE1 RULE2
		else if (sel_rise && pend_q.kind == cmd_clear_latch)
			latch_q <= 1'b0; // RULE3
		else if (cycle_end)
			latch_q <= 1'b0; // RULE4 RULE16
	end

	// self-timed cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			busy_q <= 1'b0;
			timer_q <= '0;
			cyc_status_q <= 1'b0;
			staged_q <= 8'h00;
		end
		else if (status_write_cmd_go || arr_go)
		begin
			busy_q <= 1'b1; // RULE8 RULE15
			timer_q <= '0;
			cyc_status_q <= status_write_cmd_go;
			staged_q <= pend_q.data;
		end
		else if (cycle_end)
			busy_q <= 1'b0; // RULE16
		else if (busy_q)
			timer_q <= timer_q + 1'b1;
	end

	// nonvolatile bits change only once the cycle finishes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lock_q <= STATUS_LOCK_RST; // RULE19
			psel_q <= PROTECT_SEL_RST;
		end
		else if (cycle_end && cyc_status_q)
		begin
			lock_q <= staged_q[STATUS_LOCK_POS]; // RULE17 RULE18
			psel_q <= {staged_q[PROTECT_SEL_HI_POS], staged_q[PROTECT_SEL_LO_POS]}; // RULE11
		end
	end

	// registered outputs
	status_s stat_d;
	always_comb
	begin
		stat_d.status_lock_bit = lock_q;
		stat_d.zero_bits = 3'b000; // RULE18
		stat_d.protect_sel_hi = psel_q[1];
		stat_d.protect_sel_lo = psel_q[0];
		stat_d.write_latch_bit = latch_q;
		stat_d.cycle_busy_bit = busy_q;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			status_byte <= 8'h00;
			hardware_lock_mode <= 1'b0;
			software_lock_mode <= 1'b1;
			array_wr_ok <= 1'b0;
			array_wr_reject <= 1'b0;
		end
		else
		begin
			status_byte <= stat_d; // RULE10
			hardware_lock_mode <= hw_lock_now; // RULE21
			software_lock_mode <= ~hw_lock_now;
			array_wr_ok <= arr_go;
			array_wr_reject <= array_wr_req & ~arr_go; // RULE9 RULE26
		end
	end

	// ==========================================================
	// checks
	chk_set_latch_works: assert property (@(posedge clk) disable iff (rst) // RULE2
		sel_rise && pend_q.kind == cmd_set_latch |=> latch_q ##1 status_byte[WRITE_LATCH_POS])
		else $error("latch not set after set command");
	chk_clear_latch_works: assert property (@(posedge clk) disable iff (rst) // RULE3
		sel_rise && pend_q.kind == cmd_clear_latch |=> !latch_q)
		else $error("latch not cleared after clear command");
	chk_no_latch_reject: assert property (@(posedge clk) disable iff (rst) // RULE9
		array_wr_req && !latch_q |=> array_wr_reject && !array_wr_ok)
		else $error("array write taken without latch");
	chk_status_write_cmd_needs_latch: assert property (@(posedge clk) disable iff (rst) // RULE13
		sel_rise && pend_q.kind == cmd_status_write && !latch_q && !busy_q |=> !busy_q)
		else $error("status write ran without latch");
	chk_lock_refuses_status_write_cmd: assert property (@(posedge clk) disable iff (rst) // RULE12
		sel_rise && pend_q.kind == cmd_status_write && hw_lock_now && !busy_q
		|=> (!(busy_q && cyc_status_q)) [*2])
		else $error("status write ran in lock mode");
	chk_cycle_end_clears: assert property (@(posedge clk) disable iff (rst) // RULE16
		cycle_end && !(sel_rise && pend_q.kind == cmd_set_latch)
		|=> !busy_q && !latch_q ##1 !status_byte[CYCLE_BUSY_POS])
		else $error("cycle end left busy or latch");
	chk_bits_wait_cycle: assert property (@(posedge clk) disable iff (rst) // RULE17
		busy_q && !cycle_end |=> $stable(lock_q) && $stable(psel_q))
		else $error("protection bits changed mid cycle");
	chk_zero_bits_read: assert property (@(posedge clk) disable iff (rst) // RULE18
		status_byte[6:4] == 3'b000)
		else $error("reserved status bits not zero");
	chk_whole_array_prot: assert property (@(posedge clk) disable iff (rst) // RULE26
		array_wr_req && psel_q == 2'b11 |=> array_wr_reject)
		else $error("whole array protection failed");
	chk_pin_high_exits: assert property (@(posedge clk) disable iff (rst) // RULE22
		prot_sync_q |=> !hardware_lock_mode)
		else $error("lock mode held with pin high");
	chk_lock_mode_enters: assert property (@(posedge clk) disable iff (rst) // RULE21
		lock_q && !prot_sync_q |=> hardware_lock_mode)
		else $error("lock mode not entered");
	chk_read_opcode_mode: assert property (@(posedge serial_clock) disable iff (link_rst) // RULE5
		cnt_q == OPCODE_LAST_CNT && shift_d == STATUS_READ_CMD |=> reading_q)
		else $error("status read not accepted");

	cov_status_write: cover property (@(posedge clk) disable iff (rst) status_write_cmd_go);
	cov_array_write: cover property (@(posedge clk) disable iff (rst) arr_go);
	cov_lock_entered: cover property (@(posedge clk) disable iff (rst) $rose(hardware_lock_mode));
	cov_read_busy: cover property (@(posedge serial_clock) disable iff (link_rst)
		reading_q && stat_sync_q[CYCLE_BUSY_POS] && cnt_q >= FIRST_READ_CNT);

endmodule

// ---- rtl/eeprom_status_pkg.sv ----
// constants, opcodes, types and timing for the eeprom status/protection block
// assumes a 20 MHz system clock and a serial host driving mode 0 or 3 frames
package eeprom_status_pkg;

	// ==========================================================
	// opcodes, sent most significant bit first
	localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;

	// ==========================================================
	// status byte field positions
	localparam int STATUS_LOCK_POS = 7;
	localparam int PROTECT_SEL_HI_POS = 3;
	localparam int PROTECT_SEL_LO_POS = 2;
	localparam int WRITE_LATCH_POS = 1;
	localparam int CYCLE_BUSY_POS = 0;

	// values after reset (delivered state of the nonvolatile bits)
	localparam logic STATUS_LOCK_RST = 1'b0;
	localparam logic [1:0] PROTECT_SEL_RST = 2'b00;
	localparam logic WRITE_LATCH_RST = 1'b0;

	// ==========================================================
	// serial frame bit counts
	localparam logic [4:0] OPCODE_LAST_CNT = 5'd7;
	localparam logic [4:0] DATA_LAST_CNT = 5'd15;
	localparam logic [4:0] FRAME_WRAP_CNT = 5'd16;
	localparam logic [4:0] FRAME_RESTART_CNT = 5'd9;
	localparam logic [2:0] BYTE_EDGE_BITS = 3'd0;
	localparam logic [4:0] FIRST_READ_CNT = 5'd8;

	// ==========================================================
	// protected regions, 11-bit array address
	localparam logic [10:0] QUARTER_BASE = 11'h600;
	localparam logic [10:0] HALF_BASE = 11'h400;

	// ==========================================================
	// self-timed write cycle
	localparam int CLK_MHZ = 20;
	localparam int SELF_TIMED_CYCLE_TIME_US = 5000;
	localparam int TW_CYCLES_DEF = SELF_TIMED_CYCLE_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 24;

	// ==========================================================
	// types
	typedef enum logic [1:0] {cmd_none, cmd_set_latch, cmd_clear_latch, cmd_status_write} cmd_kind_e;

	typedef struct packed {
		cmd_kind_e kind;
		logic [7:0] data;
	} link_req_s;

	typedef struct packed {
		logic status_lock_bit;
		logic [2:0] zero_bits;
		logic protect_sel_hi;
		logic protect_sel_lo;
		logic write_latch_bit;
		logic cycle_busy_bit;
	} status_s;

endpackage

// ---- dv/spi_host_model.sv ----
// serial host that drives select, clock and data frames into the status block
// assumes mode 0 framing: link clock idles low and only toggles inside a frame
`timescale 1ns/100ps

module spi_host_model
(
	// link toward the device
	output logic serial_clock,
	output logic select_n,
	output logic serial_in,
	// answer from the device
	input wire logic serial_out
);
	// ==========================================================
	// idle bus
	initial
	begin
		serial_clock = 1'b0;
		select_n = 1'b1;
		serial_in = 1'b0;
	end

	// ==========================================================
	// one frame: nbits sent msb first, then nread bytes read back
	task automatic xfer(input logic [15:0] tx, input int nbits, input int nread,
		output logic [7:0] rx);
		int i;
		rx = 8'h00;
		select_n = 1'b0;
		for (i = 0; i < nbits + 8 * nread; i++)
		begin
			// data changes while the clock is low
			serial_in = (i < nbits) ? tx[15 - i] : ~serial_in;
			#24 serial_clock = 1'b1;
			if (i >= nbits)
				rx = {rx[6:0], serial_out};
			#24 serial_clock = 1'b0;
		end
		// deselect after the last rising edge, before any further one
		select_n = 1'b1;
		serial_in = ~serial_in;
		// gap well above the minimum deselect time
		#300;
	endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the eeprom status and protection block
// assumes the host model drives the link; the bench polls busy between commands
`timescale 1ns/100ps

`define CHK(name, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			$display("wrong value %s exp %h got %h", name, exp, got); \
			errors++; \
		end \
	end

module tb_top;
	import eeprom_status_pkg::*;

	// short self-timed cycle keeps the run brief
	localparam int TW = 60;
	typedef struct {logic [15:0] tx; int nbits; logic pin; logic [7:0] exp;} row_s;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic serial_clock, select_n, serial_in, serial_out, serial_out_oe_n;
	logic protect_pin_n = 1'b1;
	logic array_wr_req = 1'b0;
	logic [10:0] array_wr_addr = 11'h000;
	logic array_wr_ok, array_wr_reject, hardware_lock_mode, software_lock_mode;
	logic [7:0] status_byte, rx;
	int errors = 0;
	int comparisons = 0;

	// ordinary command sequence: frame, pin level, status expected after it
	row_s rows [10] = '{
		'{16'h0000, 8, 1'b1, 8'h00}, '{16'h01ff, 16, 1'b1, 8'h00},
		'{16'h0600, 8, 1'b1, 8'h02}, '{16'h0400, 8, 1'b1, 8'h00},
		'{16'h0600, 9, 1'b1, 8'h00}, '{16'h0600, 8, 1'b1, 8'h02},
		'{16'h01ff, 16, 1'b0, 8'h8c}, '{16'h0600, 8, 1'b0, 8'h8e},
		'{16'h0100, 16, 1'b0, 8'h8e}, '{16'h0100, 16, 1'b1, 8'h00}};

	// ==========================================================
	// clock and instances
	always #25 clk = ~clk;

	spi_eeprom_status_protect #(.TW_CYCLES(TW)) dut_u (.clk(clk), .rst(rst),
		.serial_clock(serial_clock), .select_n(select_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
		.protect_pin_n(protect_pin_n), .array_wr_req(array_wr_req),
		.array_wr_addr(array_wr_addr), .array_wr_ok(array_wr_ok),
		.array_wr_reject(array_wr_reject), .status_byte(status_byte),
		.hardware_lock_mode(hardware_lock_mode), .software_lock_mode(software_lock_mode));

	spi_host_model host_u (.serial_clock(serial_clock), .select_n(select_n),
		.serial_in(serial_in), .serial_out(serial_out));

	// ==========================================================
	// helpers
	task automatic settle;
		int n;
		repeat (8) @(posedge clk);
		for (n = 0; n < 400 && status_byte[0] !== 1'b0; n++)
			@(posedge clk);
		repeat (4) @(posedge clk);
	endtask

	task automatic cmd(input logic [15:0] tx, input int nbits);
		@(posedge clk);
		host_u.xfer(tx, nbits, 0, rx);
		settle();
	endtask

	task automatic arr(input logic [10:0] a, input logic exp_ok);
		@(posedge clk);
		array_wr_req <= 1'b1;
		array_wr_addr <= a;
		@(posedge clk);
		array_wr_req <= 1'b0;
		@(negedge clk);
		`CHK("array ok", exp_ok, array_wr_ok);
		`CHK("array reject", ~exp_ok, array_wr_reject);
		settle();
	endtask

	task give_verdict;
		if (errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		int i, c, k;
		logic [10:0] a;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("status reset", 8'h00, status_byte);
		`CHK("oe idle", 1'b1, serial_out_oe_n);
		`CHK("soft mode", 1'b1, software_lock_mode);
		for (i = 0; i < 10; i++)
		begin
			@(posedge clk);
			protect_pin_n <= rows[i].pin;
			cmd(rows[i].tx, rows[i].nbits);
			`CHK("status", rows[i].exp, status_byte);
			host_u.xfer(16'h0500, 8, 2, rx);
			`CHK("status read", rows[i].exp, rx);
			`CHK("hw lock", rows[i].exp[7] & ~rows[i].pin, hardware_lock_mode);
			`CHK("sw lock", ~(rows[i].exp[7] & ~rows[i].pin), software_lock_mode);
		end
		// busy and delayed effect of a status write
		cmd(16'h0600, 8);
		host_u.xfer(16'h0184, 16, 0, rx);
		repeat (8) @(posedge clk);
		`CHK("busy", 8'h03, status_byte);
		host_u.xfer(16'h0500, 8, 2, rx);
		`CHK("read busy", 8'h03, rx);
		settle();
		`CHK("after cycle", 8'h84, status_byte);
		// pin low after lock set, then release by pin only
		protect_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("hw enter", 1'b1, hardware_lock_mode);
		cmd(16'h0600, 8);
		cmd(16'h0100, 16);
		`CHK("locked", 8'h86, status_byte);
		protect_pin_n <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("hw leave", 1'b0, hardware_lock_mode);
		cmd(16'h0400, 8);
		arr(11'h000, 1'b0);
		// every protect code against region edges
		for (c = 0; c < 4; c++)
		begin
			cmd(16'h0600, 8);
			cmd({8'h01, 8'(c << 2)}, 16);
			for (k = 0; k < 3; k++)
			begin
				a = (k == 0) ? 11'h3ff : (k == 1) ? 11'h5ff : 11'h600;
				cmd(16'h0600, 8);
				arr(a, !(c == 3 || (c == 2 && a >= 11'h400) || (c == 1 && a >= 11'h600)));
			end
		end
		`CHK("latch after array", 8'h0e, status_byte);
		give_verdict();
	end

	// ==========================================================
	// watchdog
	initial
	begin
		#1000000;
		errors++;
		give_verdict();
	end
endmodule
